/* design/freq_select_watchdog_recovery.sv */
`timescale 1ns/100ps

// Overview of operation
// RQ1 - Program off, override 0: frequency comes from latched strap inputs.
// RQ2 - Program off, override 1: frequency comes from software five-bit ratio code.
// RQ3 - Gear constant and group ratio follow straps or ratio code per override.
// RQ4 - Program on: CPU frequency from multiplier, divider and gear constant.
// RQ5 - Any write to multiplier or divider starts a load; host writes both together.
// RQ6 - Program on: CPU, AGP, PCI ratio follows straps or ratio code per override.
// RQ7 - Watchdog time-out switches CPU output to a recovery frequency.
// RQ8 - Recovery source 0 uses latched straps, 1 uses recovery multiplier and divider.
// RQ9 - Recovery source 1 computes recovery frequency from recovery multiplier and divider.
// RQ10 - Recovery ratio follows straps or ratio code per override.
// RQ11 - Any write to either recovery value starts a load; host writes both together.
// RQ12 - Watchdog run 0 stops the counter and reloads the time-out value.
// RQ13 - Watchdog run 1 counts down only after a frequency change.
// RQ14 - Count reaching zero sets the sticky expired flag.
// RQ15 - Expired flag reads 1 after time-out; writing 1 clears, 0 ignored.
// RQ16 - Time-out held as five-bit field in prescaler units.
// RQ17 - Short unit gives time-outs from 150 ms to 4.8 s.
// RQ18 - Long unit gives time-outs from 2.5 s to 80 s.
// RQ19 - Field value v means v+1 prescaler units.
// RQ20 - Unit choice 0 is the 150 ms unit, 1 the 2.5 s unit.
module freq_select_watchdog_recovery #(
    parameter int unsigned SHORT_UNIT_CYCLES = freq_select_pkg::WATCHDOG_SHORT_CYCLES,
    parameter int unsigned LONG_UNIT_CYCLES  = freq_select_pkg::WATCHDOG_LONG_CYCLES,
    parameter int          UNIT_CNT_W        = freq_select_pkg::WATCHDOG_UNIT_CNT_W
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  freq_select_pkg::reg_wr_t       regWr,
    input  wire logic [2:0]                rdIndex,
    output logic [7:0]                     rdData,
    input  wire logic [4:0]                strapFreqInputs,
    output freq_select_pkg::pll_cmd_t      pllCmd,
    output logic                           freqLoad,
    output logic                           recoveryActive,
    output logic                           watchdogExpired
);

    function automatic logic isWrite(input freq_select_pkg::reg_wr_t wr, input logic [2:0] idx);
        isWrite = wr.en && (wr.index == idx);
    endfunction

    // ==================================================================
    // Strap capture
    logic [4:0] strapSync1_q;
    logic [4:0] strapSync2_q;
    logic [4:0] strapLatched_q;
    logic [1:0] strapSettle_q;
    logic       strapDone_q;
    logic       strapTake;

    assign strapTake = !strapDone_q && (strapSettle_q == 2'(freq_select_pkg::STRAP_SETTLE_CYCLES));

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            strapSync1_q   <= 5'h0;
            strapSync2_q   <= 5'h0;
            strapLatched_q <= freq_select_pkg::CODE_RESET;
            strapSettle_q  <= 2'h0;
            strapDone_q    <= 1'b0;
        end
        else
        begin
            strapSync1_q <= strapFreqInputs;
            strapSync2_q <= strapSync1_q;
            if (!strapDone_q)
                strapSettle_q <= strapSettle_q + 2'h1;
            if (strapTake)
            begin
                strapLatched_q <= strapSync2_q;
                strapDone_q    <= 1'b1;
            end
        end
    end

    // ==================================================================
    // Control bytes
    logic       progFreqEn_q;
    logic       ratioSourceOverride_q;
    logic       recoverySourceChoice_q;
    logic       watchdogRun_q;
    logic       watchdogUnitChoice_q;
    logic [4:0] ratioCode_q;
    logic [7:0] cpuMultiplier_q;
    logic [6:0] cpuDivider_q;
    logic [7:0] recoveryMultiplier_q;
    logic [6:0] recoveryDivider_q;
    logic [4:0] watchdogTimeoutCount_q;
    logic       watchdogExpiredFlag_q;
    logic       watchdogExpiredFlag_d;
    logic       recoveryActive_q;
    logic       recoveryActive_d;
    logic       ctrlWrite;
    logic       flagClear;
    logic       expire;

    assign ctrlWrite = isWrite(regWr, freq_select_pkg::CB_CONTROL);
    assign flagClear = ctrlWrite && regWr.data[freq_select_pkg::BIT_EXPIRED_FLAG]; // [RQ15]
    // A time-out in the clearing cycle wins over the clear.
    assign watchdogExpiredFlag_d = expire || (watchdogExpiredFlag_q && !flagClear); // [RQ14] [RQ15]
    assign recoveryActive_d      = expire || (recoveryActive_q && !flagClear); // [RQ7]

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            progFreqEn_q           <= 1'b0;
            ratioSourceOverride_q  <= 1'b0;
            recoverySourceChoice_q <= 1'b0;
            watchdogRun_q          <= 1'b0;
            watchdogUnitChoice_q   <= 1'b0;
            ratioCode_q            <= freq_select_pkg::CODE_RESET;
            cpuMultiplier_q        <= freq_select_pkg::MUL_RESET;
            cpuDivider_q           <= freq_select_pkg::DIV_RESET;
            recoveryMultiplier_q   <= freq_select_pkg::MUL_RESET;
            recoveryDivider_q      <= freq_select_pkg::DIV_RESET;
            watchdogTimeoutCount_q <= freq_select_pkg::TIMEOUT_RESET;
            watchdogExpiredFlag_q  <= 1'b0;
            recoveryActive_q       <= 1'b0;
        end
        else
        begin
            if (ctrlWrite)
            begin
                progFreqEn_q           <= regWr.data[freq_select_pkg::BIT_PROG_EN];
                ratioSourceOverride_q  <= regWr.data[freq_select_pkg::BIT_RATIO_OVERRIDE];
                recoverySourceChoice_q <= regWr.data[freq_select_pkg::BIT_RECOVERY_SOURCE];
                watchdogRun_q          <= regWr.data[freq_select_pkg::BIT_WATCHDOG_RUN];
                watchdogUnitChoice_q   <= regWr.data[freq_select_pkg::BIT_UNIT_CHOICE];
            end
            if (isWrite(regWr, freq_select_pkg::CB_RATIO_CODE))
                ratioCode_q <= regWr.data[4:0];
            if (isWrite(regWr, freq_select_pkg::CB_CPU_MUL))
                cpuMultiplier_q <= regWr.data;
            if (isWrite(regWr, freq_select_pkg::CB_CPU_DIV))
                cpuDivider_q <= regWr.data[6:0];
            if (isWrite(regWr, freq_select_pkg::CB_REC_MUL))
                recoveryMultiplier_q <= regWr.data;
            if (isWrite(regWr, freq_select_pkg::CB_REC_DIV))
                recoveryDivider_q <= regWr.data[6:0];
            if (isWrite(regWr, freq_select_pkg::CB_TIMEOUT))
                watchdogTimeoutCount_q <= regWr.data[4:0]; // [RQ16]
            watchdogExpiredFlag_q <= watchdogExpiredFlag_d;
            recoveryActive_q      <= recoveryActive_d;
        end
    end

    // ==================================================================
    // Frequency selection
    freq_select_pkg::pll_cmd_t cmdNext;
    freq_select_pkg::pll_cmd_t pllCmd_q;
    logic [4:0] activeRatio;
    logic       normalProgram;
    logic       recoveryProgram;
    logic       activePairWrite;
    logic       pairTouched_q;
    logic       freqLoad_q;

    assign activeRatio     = ratioSourceOverride_q ? ratioCode_q : strapLatched_q; // [RQ3] [RQ6] [RQ10]
    assign normalProgram   = !recoveryActive_q && progFreqEn_q;
    assign recoveryProgram = recoveryActive_q && recoverySourceChoice_q; // [RQ8]

    assign cmdNext.programmed = normalProgram || recoveryProgram; // [RQ4] [RQ9]
    // Strap source in recovery ignores the override for the frequency itself.
    assign cmdNext.freqCode   = recoveryActive_q ? strapLatched_q : activeRatio; // [RQ1] [RQ2] [RQ8]
    assign cmdNext.ratioCode  = activeRatio;
    assign cmdNext.multiplier = recoveryActive_q ? recoveryMultiplier_q : cpuMultiplier_q; // [RQ9]
    assign cmdNext.divider    = recoveryActive_q ? recoveryDivider_q : cpuDivider_q; // [RQ4]

    // Rewriting an equal value still counts as an update that reloads.
    assign activePairWrite =
        (normalProgram && (isWrite(regWr, freq_select_pkg::CB_CPU_MUL) ||
                           isWrite(regWr, freq_select_pkg::CB_CPU_DIV))) || // [RQ5]
        (recoveryProgram && (isWrite(regWr, freq_select_pkg::CB_REC_MUL) ||
                             isWrite(regWr, freq_select_pkg::CB_REC_DIV))); // [RQ11]

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pllCmd_q      <= '0;
            pairTouched_q <= 1'b0;
            freqLoad_q    <= 1'b0;
        end
        else
        begin
            pllCmd_q      <= cmdNext;
            pairTouched_q <= activePairWrite;
            freqLoad_q    <= pairTouched_q || (cmdNext != pllCmd_q); // [RQ5] [RQ11]
        end
    end

    // ==================================================================
    // Watchdog
    freq_select_pkg::watchdog_state_t wdState_q;
    freq_select_pkg::watchdog_state_t wdState_d;
    logic [5:0] wdRemain_q;
    logic [5:0] wdRemain_d;
    logic [5:0] wdReload;
    logic       unitTick;
    logic       arm;

    assign wdReload = {1'b0, watchdogTimeoutCount_q} + 6'h01; // [RQ19]
    // Entering recovery changes the frequency but must not re-arm.
    assign arm      = watchdogRun_q && freqLoad_q && !recoveryActive_q; // [RQ13]
    assign expire   = (wdState_q == freq_select_pkg::WATCHDOG_COUNTING) && watchdogRun_q &&
                      !arm && unitTick && (wdRemain_q == 6'h01); // [RQ14]

    always_comb
    begin
        wdState_d  = wdState_q;
        wdRemain_d = wdRemain_q;
        unique case (wdState_q)
            freq_select_pkg::WATCHDOG_IDLE:
            begin
                if (!watchdogRun_q)
                    wdRemain_d = wdReload; // [RQ12]
                else if (arm)
                begin
                    wdState_d  = freq_select_pkg::WATCHDOG_COUNTING; // [RQ13]
                    wdRemain_d = wdReload;
                end
            end
            freq_select_pkg::WATCHDOG_COUNTING:
            begin
                if (!watchdogRun_q)
                begin
                    wdState_d  = freq_select_pkg::WATCHDOG_IDLE; // [RQ12]
                    wdRemain_d = wdReload;
                end
                else if (arm)
                    wdRemain_d = wdReload;
                else if (unitTick)
                begin
                    wdRemain_d = wdRemain_q - 6'h01;
                    if (wdRemain_q == 6'h01)
                        wdState_d = freq_select_pkg::WATCHDOG_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wdState_q  <= freq_select_pkg::WATCHDOG_IDLE;
            wdRemain_q <= 6'h01;
        end
        else
        begin
            wdState_q  <= wdState_d;
            wdRemain_q <= wdRemain_d;
        end
    end

    wd_unit_tick #(
        .SHORT_CYCLES (SHORT_UNIT_CYCLES),
        .LONG_CYCLES  (LONG_UNIT_CYCLES),
        .CNT_W        (UNIT_CNT_W)
    ) unitTicker (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .run      (wdState_q == freq_select_pkg::WATCHDOG_COUNTING),
        .restart  (arm),
        .longUnit (watchdogUnitChoice_q), // [RQ17] [RQ18] [RQ20]
        .tick     (unitTick)
    );

    // ==================================================================
    // Readback
    logic [7:0] ctrlByte;
    logic [7:0] rdNext;
    logic [7:0] rdData_q;

    assign ctrlByte = {1'b0, recoveryActive_q, watchdogExpiredFlag_q, watchdogUnitChoice_q,
                       watchdogRun_q, recoverySourceChoice_q, ratioSourceOverride_q,
                       progFreqEn_q}; // [RQ15]
    assign rdNext =
        (rdIndex == freq_select_pkg::CB_CONTROL)    ? ctrlByte :
        (rdIndex == freq_select_pkg::CB_RATIO_CODE) ? {3'h0, ratioCode_q} :
        (rdIndex == freq_select_pkg::CB_CPU_MUL)    ? cpuMultiplier_q :
        (rdIndex == freq_select_pkg::CB_CPU_DIV)    ? {1'b0, cpuDivider_q} :
        (rdIndex == freq_select_pkg::CB_REC_MUL)    ? recoveryMultiplier_q :
        (rdIndex == freq_select_pkg::CB_REC_DIV)    ? {1'b0, recoveryDivider_q} :
        (rdIndex == freq_select_pkg::CB_TIMEOUT)    ? {3'h0, watchdogTimeoutCount_q} :
                                                      {3'h0, strapLatched_q};

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rdData_q <= 8'h00;
        else
            rdData_q <= rdNext;
    end

    assign rdData          = rdData_q;
    assign pllCmd          = pllCmd_q;
    assign freqLoad        = freqLoad_q;
    assign recoveryActive  = recoveryActive_q;
    assign watchdogExpired = watchdogExpiredFlag_q;

    // ==================================================================
    // Checks
    property p_strapFreq;
        @(posedge clk_sys) disable iff (rst)
        (!progFreqEn_q && !ratioSourceOverride_q && !recoveryActive_q)
            |=> (!pllCmd.programmed && pllCmd.freqCode == $past(strapLatched_q));
    endproperty
    a_strapFreq: assert property (p_strapFreq) else $error("strap frequency not selected"); // [RQ1]

    property p_codeFreq;
        @(posedge clk_sys) disable iff (rst)
        (!progFreqEn_q && ratioSourceOverride_q && !recoveryActive_q)
            |=> (!pllCmd.programmed && pllCmd.freqCode == $past(ratioCode_q));
    endproperty
    a_codeFreq: assert property (p_codeFreq) else $error("ratio code frequency not selected"); // [RQ2]

    property p_ratioSource;
        @(posedge clk_sys) disable iff (rst)
        1'b1 |=> pllCmd.ratioCode ==
                 ($past(ratioSourceOverride_q) ? $past(ratioCode_q) : $past(strapLatched_q));
    endproperty
    a_ratioSource: assert property (p_ratioSource) else $error("ratio source wrong"); // [RQ3]

    property p_programFreq;
        @(posedge clk_sys) disable iff (rst)
        (progFreqEn_q && !recoveryActive_q) |=> (pllCmd.programmed &&
            pllCmd.multiplier == $past(cpuMultiplier_q) && pllCmd.divider == $past(cpuDivider_q));
    endproperty
    a_programFreq: assert property (p_programFreq) else $error("programmed pair not used"); // [RQ4]

    sequence s_cpuPairWrite;
        progFreqEn_q && !recoveryActive_q && !expire &&
        (isWrite(regWr, freq_select_pkg::CB_CPU_MUL) || isWrite(regWr, freq_select_pkg::CB_CPU_DIV));
    endsequence
    property p_cpuLoad;
        @(posedge clk_sys) disable iff (rst)
        s_cpuPairWrite |-> ##2 freqLoad;
    endproperty
    a_cpuLoad: assert property (p_cpuLoad) else $error("no load after pair write"); // [RQ5]

    property p_recoverEntry;
        @(posedge clk_sys) disable iff (rst)
        expire |=> (recoveryActive && watchdogExpired) ##1 (pllCmd.multiplier ==
            $past(recoveryMultiplier_q) && pllCmd.programmed == $past(recoverySourceChoice_q));
    endproperty
    a_recoverEntry: assert property (p_recoverEntry) else $error("recovery not entered"); // [RQ7]

    property p_recoveryStrap;
        @(posedge clk_sys) disable iff (rst)
        (recoveryActive_q && !recoverySourceChoice_q)
            |=> (!pllCmd.programmed && pllCmd.freqCode == $past(strapLatched_q));
    endproperty
    a_recoveryStrap: assert property (p_recoveryStrap) else $error("recovery strap not used"); // [RQ8]

    property p_stopReload;
        @(posedge clk_sys) disable iff (rst)
        !watchdogRun_q |=> (wdState_q == freq_select_pkg::WATCHDOG_IDLE &&
                            wdRemain_q == {1'b0, $past(watchdogTimeoutCount_q)} + 6'h01);
    endproperty
    a_stopReload: assert property (p_stopReload) else $error("watchdog not reloaded"); // [RQ12]

    property p_waitForChange;
        @(posedge clk_sys) disable iff (rst)
        (wdState_q == freq_select_pkg::WATCHDOG_IDLE && watchdogRun_q && !freqLoad_q)
            |=> (wdState_q == freq_select_pkg::WATCHDOG_IDLE && !expire);
    endproperty
    a_waitForChange: assert property (p_waitForChange) else $error("counted without change"); // [RQ13]

    property p_expireSets;
        @(posedge clk_sys) disable iff (rst)
        (wdState_q == freq_select_pkg::WATCHDOG_COUNTING && watchdogRun_q && !arm &&
         unitTick && wdRemain_q == 6'h01) |=> (watchdogExpired && wdRemain_q == 6'h00);
    endproperty
    a_expireSets: assert property (p_expireSets) else $error("zero count did not set flag"); // [RQ14]

    sequence s_clearOnly;
        flagClear && !expire;
    endsequence
    property p_flagClear;
        @(posedge clk_sys) disable iff (rst)
        s_clearOnly |=> (!watchdogExpired && !recoveryActive);
    endproperty
    a_flagClear: assert property (p_flagClear) else $error("flag not cleared"); // [RQ15]

    property p_zeroWriteKeeps;
        @(posedge clk_sys) disable iff (rst)
        (watchdogExpiredFlag_q && ctrlWrite && !regWr.data[freq_select_pkg::BIT_EXPIRED_FLAG])
            |=> watchdogExpired;
    endproperty
    a_zeroWriteKeeps: assert property (p_zeroWriteKeeps) else $error("zero write cleared"); // [RQ15]

endmodule // freq_select_watchdog_recovery

/* design/freq_select_pkg.sv */
package freq_select_pkg;

    // ==================================================================
    // Control byte indices
    localparam logic [2:0] CB_CONTROL      = 3'h0;
    localparam logic [2:0] CB_RATIO_CODE   = 3'h1;
    localparam logic [2:0] CB_CPU_MUL      = 3'h2;
    localparam logic [2:0] CB_CPU_DIV      = 3'h3;
    localparam logic [2:0] CB_REC_MUL      = 3'h4;
    localparam logic [2:0] CB_REC_DIV      = 3'h5;
    localparam logic [2:0] CB_TIMEOUT      = 3'h6;
    localparam logic [2:0] CB_STRAP        = 3'h7;

    // ==================================================================
    // Control byte field positions
    localparam int BIT_PROG_EN         = 0;
    localparam int BIT_RATIO_OVERRIDE  = 1;
    localparam int BIT_RECOVERY_SOURCE = 2;
    localparam int BIT_WATCHDOG_RUN    = 3;
    localparam int BIT_UNIT_CHOICE     = 4;
    localparam int BIT_EXPIRED_FLAG    = 5;
    localparam int BIT_RECOVERY_ACTIVE = 6;

    // ==================================================================
    // Reset values
    localparam logic [7:0] MUL_RESET      = 8'h00;
    localparam logic [6:0] DIV_RESET      = 7'h00;
    localparam logic [4:0] CODE_RESET     = 5'h00;
    localparam logic [4:0] TIMEOUT_RESET  = 5'h00;

    // ==================================================================
    // Timing
    localparam longint CLK_HZ              = 40_000_000;
    localparam longint WATCHDOG_SHORT_MS   = 150;
    localparam longint WATCHDOG_LONG_MS    = 2500;
    localparam int unsigned WATCHDOG_SHORT_CYCLES = int'((WATCHDOG_SHORT_MS * CLK_HZ) / 1000);
    localparam int unsigned WATCHDOG_LONG_CYCLES  = int'((WATCHDOG_LONG_MS * CLK_HZ) / 1000);
    localparam int WATCHDOG_UNIT_CNT_W    = 27;
    localparam int STRAP_SETTLE_CYCLES    = 2;

    // ==================================================================
    // Carriers
    typedef struct packed {
        logic       en;
        logic [2:0] index;
        logic [7:0] data;
    } reg_wr_t;

    typedef struct packed {
        logic       programmed;
        logic [4:0] freqCode;
        logic [4:0] ratioCode;
        logic [7:0] multiplier;
        logic [6:0] divider;
    } pll_cmd_t;

    typedef enum logic [0:0] {
        WATCHDOG_IDLE,
        WATCHDOG_COUNTING
    } watchdog_state_t;

endpackage

/* design/wd_unit_tick.sv */
`timescale 1ns/100ps

// Produces one pulse per elapsed watchdog unit while running.
module wd_unit_tick #(
    parameter int unsigned SHORT_CYCLES = freq_select_pkg::WATCHDOG_SHORT_CYCLES,
    parameter int unsigned LONG_CYCLES  = freq_select_pkg::WATCHDOG_LONG_CYCLES,
    parameter int          CNT_W        = freq_select_pkg::WATCHDOG_UNIT_CNT_W
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic restart,
    input  wire logic longUnit,
    output logic      tick
);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic [CNT_W-1:0] lastCount;
    logic             wrap;
    logic             tick_q;

    assign lastCount = longUnit ? CNT_W'(LONG_CYCLES - 1) : CNT_W'(SHORT_CYCLES - 1);
    assign wrap      = run && !restart && (count_q >= lastCount);
    assign count_d   = (!run || restart || wrap) ? '0 : count_q + CNT_W'(1);
    assign tick      = tick_q;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            count_q <= '0;
            tick_q  <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            tick_q  <= wrap;
        end
    end

endmodule // wd_unit_tick

/* verification/smbus_host_model.sv */
`timescale 1ns/100ps

// ==================================================================
// Host model: one control byte write per cycle, released data inverted.
module smbus_host_model (
    input  wire logic               clk_sys,
    output freq_select_pkg::reg_wr_t regWr
);
    initial regWr = '0;

    task automatic put(input logic [2:0] idx, input logic [7:0] val);
        @(posedge clk_sys);
        regWr <= '{1'b1, idx, val};
        @(posedge clk_sys);
        regWr <= '{1'b0, idx, ~val};
    endtask

    // Both bytes of a pair go out on consecutive cycles.
    task automatic pair(input logic [2:0] idx, input logic [7:0] a, input logic [7:0] b);
        @(posedge clk_sys);
        regWr <= '{1'b1, idx, a};
        @(posedge clk_sys);
        regWr <= '{1'b1, idx + 3'h1, b};
        @(posedge clk_sys);
        regWr <= '{1'b0, idx, ~b};
    endtask
endmodule // smbus_host_model

/* verification/freq_select_watchdog_recovery_tb.sv */
`timescale 1ns/100ps

// ==================================================================
// Scenario bench for frequency selection and watchdog recovery.
module freq_select_watchdog_recovery_tb;
    logic                      clk_sys = 1'b0;
    logic                      rst     = 1'b1;
    logic [2:0]                rdIndex = 3'h0;
    logic [7:0]                rdData;
    logic [7:0]                d;
    freq_select_pkg::reg_wr_t  regWr;
    freq_select_pkg::pll_cmd_t pllCmd;
    logic                      freqLoad;
    logic                      recoveryActive;
    logic                      watchdogExpired;
    int                        n_fail   = 0;
    int                        compares = 0;
    int                        loads    = 0;
    int                        n;
    int                        l0;
    localparam logic [4:0]     STRAP = 5'h0B;
    logic [4:0]                strapPins = 5'h0B;

    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (freqLoad === 1'b1) loads <= loads + 1;

    freq_select_watchdog_recovery #(
        .SHORT_UNIT_CYCLES(10),
        .LONG_UNIT_CYCLES (40)
    ) uut (
        .clk_sys(clk_sys), .rst(rst), .regWr(regWr), .rdIndex(rdIndex),
        .rdData(rdData), .strapFreqInputs(strapPins), .pllCmd(pllCmd),
        .freqLoad(freqLoad), .recoveryActive(recoveryActive),
        .watchdogExpired(watchdogExpired)
    );

    smbus_host_model host (.clk_sys(clk_sys), .regWr(regWr));

    function automatic logic [7:0] ctl(input logic p, o, s, r, u, c);
        ctl = 8'h00;
        ctl[freq_select_pkg::BIT_PROG_EN] = p;
        ctl[freq_select_pkg::BIT_RATIO_OVERRIDE] = o;
        ctl[freq_select_pkg::BIT_RECOVERY_SOURCE] = s;
        ctl[freq_select_pkg::BIT_WATCHDOG_RUN] = r;
        ctl[freq_select_pkg::BIT_UNIT_CHOICE] = u;
        ctl[freq_select_pkg::BIT_EXPIRED_FLAG] = c;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    task automatic rd(input logic [2:0] idx);
        @(posedge clk_sys);
        rdIndex <= idx;
        settle(2);
        d = rdData;
    endtask

    // Cycles from the arming load to the expired flag, bounded.
    task automatic measure;
        int k;
        for (k = 0; k < 20 && freqLoad !== 1'b1; k++) settle(1);
        for (n = 0; n < 300 && watchdogExpired !== 1'b1; n++) settle(1);
        if (k == 20 || n == 300)
        begin
            n_fail++;
            end_sim();
        end
    endtask

    task automatic s_select;
        host.put(freq_select_pkg::CB_TIMEOUT, 8'hFF);
        rd(freq_select_pkg::CB_TIMEOUT);
        check("timeout field", d, 8'h1F);
        // Pins move after the latch point; the latched copy must not follow them.
        @(posedge clk_sys);
        strapPins <= 5'h04;
        rd(freq_select_pkg::CB_STRAP);
        check("strap latched", d, {3'h0, STRAP});
        host.put(freq_select_pkg::CB_RATIO_CODE, 8'h15);
        host.put(freq_select_pkg::CB_CONTROL, ctl(0, 1, 0, 0, 0, 0));
        settle(4);
        check("code freq", pllCmd.freqCode, 5'h15);
        check("code ratio", pllCmd.ratioCode, 5'h15);
        host.put(freq_select_pkg::CB_CONTROL, ctl(0, 0, 0, 0, 0, 0));
        settle(4);
        check("strap freq", pllCmd.freqCode, STRAP);
        check("strap ratio", pllCmd.ratioCode, STRAP);
    endtask

    task automatic s_program;
        host.put(freq_select_pkg::CB_CONTROL, ctl(1, 1, 0, 0, 0, 0));
        settle(4);
        l0 = loads;
        host.pair(freq_select_pkg::CB_CPU_MUL, 8'h40, 8'h23);
        settle(4);
        check("pair loads", loads - l0, 2);
        check("prog cmd", {pllCmd.programmed, pllCmd.multiplier, pllCmd.divider},
              {1'b1, 8'h40, 7'h23});
        check("prog ratio", pllCmd.ratioCode, 5'h15);
    endtask

    task automatic s_watch;
        host.put(freq_select_pkg::CB_TIMEOUT, 8'h02);
        host.put(freq_select_pkg::CB_CONTROL, ctl(1, 1, 0, 1, 0, 0));
        host.put(freq_select_pkg::CB_CPU_MUL, 8'h41);
        measure();
        check("short span", n >= 30 && n <= 34, 1);
        check("recovery on", recoveryActive, 1'b1);
        settle(3);
        check("rec strap", {pllCmd.programmed, pllCmd.freqCode}, {1'b0, STRAP});
        rd(freq_select_pkg::CB_CONTROL);
        check("flag read", d[freq_select_pkg::BIT_EXPIRED_FLAG], 1'b1);
        host.put(freq_select_pkg::CB_CONTROL, ctl(1, 1, 0, 1, 0, 0));
        settle(2);
        check("write 0 keeps", watchdogExpired, 1'b1);
        host.put(freq_select_pkg::CB_CONTROL, ctl(1, 1, 0, 0, 0, 1));
        settle(2);
        check("write 1 clears", watchdogExpired, 1'b0);
        host.pair(freq_select_pkg::CB_REC_MUL, 8'h55, 8'h0A);
        host.put(freq_select_pkg::CB_TIMEOUT, 8'h00);
        host.put(freq_select_pkg::CB_CONTROL, ctl(1, 1, 1, 1, 1, 0));
        host.put(freq_select_pkg::CB_CPU_MUL, 8'h42);
        measure();
        check("long span", n >= 40 && n <= 44, 1);
        settle(3);
        check("rec prog", {pllCmd.programmed, pllCmd.multiplier, pllCmd.divider},
              {1'b1, 8'h55, 7'h0A});
        check("rec ratio", pllCmd.ratioCode, 5'h15);
        l0 = loads;
        host.put(freq_select_pkg::CB_REC_MUL, 8'h56);
        settle(3);
        check("rec reload", loads - l0, 1);
        check("rec mul", pllCmd.multiplier, 8'h56);
        host.put(freq_select_pkg::CB_CONTROL, ctl(1, 1, 0, 0, 0, 1));
    endtask

    task automatic s_stop;
        host.put(freq_select_pkg::CB_CPU_MUL, 8'h43);
        settle(60);
        check("stopped", watchdogExpired, 1'b0);
        host.put(freq_select_pkg::CB_CONTROL, ctl(1, 1, 0, 1, 0, 0));
        settle(60);
        check("no change idle", watchdogExpired, 1'b0);
    endtask

    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        settle(5);
        s_select();
        s_program();
        s_watch();
        s_stop();
        end_sim();
    end
endmodule // freq_select_watchdog_recovery_tb
